// ==== dv/nibble_swap_xor_subtract_alu_tb.sv ====
module nibble_swap_xor_subtract_alu_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nsxalu_pkg::*;
  logic sys_clk = 0, rst_n = 0, vld = 0;
  logic [13:0] wd = '0;
  logic [7:0] rd, acc, s = 8'h24;
  logic [5:0] tp;
  logic carry, zero;
  nsxalu_req_t req;
  nsxalu_wr_t regWr;
  int m[128], ea, ec, ez, ew, eaddr, edat, t, r, n_fail, samples_checked;
  logic [5:0] tops[6] = '{6'h0E, 6'h02, 6'h3A, 6'h3C, 6'h3D, 6'h3F};
  // 14'h0280: register 0 equals the accumulator, result goes back to the register
  logic [13:0] dir[9] = '{14'h3A03, 14'h0280, 14'h3C03, 14'h3A03, 14'h3C02, 14'h0EFF, 14'h02FF, 14'h0E05,
    14'h3AAF};
  assign req = {vld, wd, rd};
  nsxalu_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .regWr(regWr), .acc(acc), .carry(carry),
    .zero(zero));
  nsxalu_regfile far (.sys_clk(sys_clk), .addr(wd[6:0]), .regWr(regWr), .regData(rd));
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // results of the previous op are checked while the next one is issued
  task automatic issue(input logic v, input logic [13:0] w);
    int d;
    @(posedge sys_clk);
    vld <= v;
    wd <= w;
    @(negedge sys_clk);
    chk(acc, 8'(ea));
    chk({7'h00, carry}, 8'(ec));
    chk({7'h00, zero}, 8'(ez));
    chk({7'h00, regWr.wrEn}, 8'(ew));
    if (ew) begin
      chk({1'h0, regWr.addr}, 8'(eaddr));
      chk(regWr.data, 8'(edat));
    end
    ew = 0;
    if (!v) return;
    t = w >> 8;
    r = m[w[6:0]];
    d = w[7];
    if (t == 6'h0E) r = {r[3:0], r[7:4]};
    else if (t == 6'h02 || t == 6'h3C || t == 6'h3D) begin
      if (t != 6'h02) begin
        r = w[7:0];
        d = 0;
      end
      ec = r >= ea;
      r = (r - ea) & 8'hFF;
      ez = r == 0;
    end else if (t == 6'h3A) begin
      r = ea ^ w[7:0];
      d = 0;
      ez = r == 0;
    end else return;
    if (d) begin
      ew = 1;
      eaddr = w[6:0];
      edat = r;
      m[eaddr] = r;
    end else ea = r;
  endtask
  initial begin
    for (int i = 0; i < 128; i++) m[i] = (i * 7 + 3) & 8'hFF;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    foreach (dir[i]) issue(1, dir[i]);
    // mid-run reset: state clears, the register file keeps its contents
    issue(0, '0);
    @(posedge sys_clk);
    rst_n <= 0;
    ea = 0;
    ec = 0;
    ez = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 400; i++) begin
      s = lfsr(s);
      tp = tops[s % 6];
      s = lfsr(s);
      issue(i % 9 != 0, {tp, s});
    end
    issue(0, '0);
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule

// ==== dv/nsxalu_regfile.sv ====
module nsxalu_regfile (
  // clock
  input wire logic sys_clk,
  // read and write side
  input wire logic [6:0] addr,
  input nsxalu_pkg::nsxalu_wr_t regWr,
  output logic [7:0] regData
);
  timeunit 1ns;
  timeprecision 1ns;
  import nsxalu_pkg::*;
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 7 + 3);
  // plain always: the array is also preset by the initial block
  always @(posedge sys_clk) if (regWr.wrEn) mem[regWr.addr] <= regWr.data;
  // bypass, as back-to-back ops may read a write still in flight
  assign regData = (regWr.wrEn && regWr.addr == addr) ? regWr.data : mem[addr];
endmodule

// ==== hdl/nsxalu_core.sv ====
// Function
// - swap nibbles, leave flags unchanged
// - dest bit 0 accumulator, 1 register
// - 7-bit address, destination bit, one cycle
// - xor literal into accumulator, zero only
// - decode xor encoding, one cycle
// - carry set when difference not negative
// - negative difference clears carry, wraps
// - equal operands give zero, carry set
`include "nsxalu_regs.svh"
module nsxalu_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // decoder request
  input nsxalu_pkg::nsxalu_req_t req,
  // register file write and state
  output nsxalu_pkg::nsxalu_wr_t regWr,
  output logic [7:0] acc,
  output logic carry,
  output logic zero
);
  import nsxalu_pkg::*;

  logic rstSync1;
  logic rstSync2;
  nsxalu_op_t op;
  logic [7:0] next_acc;
  logic next_carry;
  logic next_zero;
  nsxalu_wr_t next_regWr;
  logic [7:0] result;
  logic [8:0] diff;
  logic dest;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'h0;
      rstSync2 <= 1'h0;
    end else begin
      rstSync1 <= 1'h1;
      rstSync2 <= rstSync1;
    end
  end

  nsxalu_decode u_decode (
    .word(req.word),
    .valid(req.valid),
    .op(op)
  );

  assign dest = req.word[7];

  always_comb begin
    next_acc = acc;
    next_carry = carry;
    next_zero = zero;
    next_regWr = '{wrEn: 1'h0, addr: req.word[6:0], data: 8'h00};
    result = 8'h00;
    diff = 9'h000;
    case (op)
      NSXALU_SWAP: begin
        result = {req.regData[3:0], req.regData[7:4]};
      end
      NSXALU_XOR: begin
        result = acc ^ req.word[7:0];
        next_zero = (result == 8'h00);
        next_acc = result;
      end
      NSXALU_SUBLIT: begin
        diff = {1'h0, req.word[7:0]} - {1'h0, acc};
        result = diff[7:0];
        next_carry = ~diff[8];
        next_zero = (result == 8'h00);
        next_acc = result;
      end
      NSXALU_SUBREG: begin
        diff = {1'h0, req.regData} - {1'h0, acc};
        result = diff[7:0];
        next_carry = ~diff[8];
        next_zero = (result == 8'h00);
      end
      default: begin
        result = 8'h00;
      end
    endcase
    if (op == NSXALU_SWAP || op == NSXALU_SUBREG) begin
      if (dest == `NSXALU_DEST_REG) begin
        next_regWr.wrEn = 1'h1;
        next_regWr.data = result;
      end else begin
        next_acc = result;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync2) begin
    if (!rstSync2) begin
      acc <= `NSXALU_ACC_RST;
      carry <= `NSXALU_FLAG_RST;
      zero <= `NSXALU_FLAG_RST;
      regWr <= '0;
    end else begin
      acc <= next_acc;
      carry <= next_carry;
      zero <= next_zero;
      regWr <= next_regWr;
    end
  end

  // checks
  // operation classes used by the properties below
  sequence s_regDestOp;
    (op == NSXALU_SWAP || op == NSXALU_SUBREG) && dest;
  endsequence

  sequence s_accDestOp;
    (op == NSXALU_SWAP || op == NSXALU_SUBREG) && !dest;
  endsequence

  // register write then an idle slot: the strobe must drop
  sequence s_idleAfterWrite;
    s_regDestOp ##1 (op == NSXALU_NOP);
  endsequence

  // two literal xors back to back, no stall between them
  sequence s_xorPair;
    (op == NSXALU_XOR) ##1 (op == NSXALU_XOR);
  endsequence

  property p_swapAcc;
    @(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SWAP && !dest) |=> acc == {$past(req.regData[3:0]), $past(req.regData[7:4])};
  endproperty

  chk_swap_to_acc: assert property (p_swapAcc) else $error("swap into accumulator wrong");

  chk_swap_to_reg: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SWAP && dest) |=> regWr.data == {$past(req.regData[3:0]), $past(req.regData[7:4])})
    else $error("swap into register wrong");

  chk_swap_flags_kept: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_SWAP |=> $stable(carry) && $stable(zero))
    else $error("swap changed a flag");

  chk_dest_reg_write: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    s_regDestOp |=> regWr.wrEn && $stable(acc))
    else $error("register destination not written");

  chk_dest_acc_nowr: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    s_accDestOp |=> !regWr.wrEn)
    else $error("accumulator destination wrote register");

  chk_swap_addr: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SWAP && dest) |=> regWr.addr == $past(req.word[6:0]))
    else $error("swap address wrong");

  chk_subreg_addr: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SUBREG && dest) |=> regWr.addr == $past(req.word[6:0]))
    else $error("subtract address wrong");

  // a stale strobe would write the register file twice
  chk_wr_single_pulse: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    s_idleAfterWrite |=> !regWr.wrEn)
    else $error("write strobe longer than one cycle");

  chk_idle_holds: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_NOP |=> $stable(acc) && $stable(carry) && $stable(zero) && !regWr.wrEn)
    else $error("idle slot changed state");

  chk_xor_result: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_XOR |=> acc == ($past(acc) ^ $past(req.word[7:0])) && $stable(carry))
    else $error("xor result wrong");

  chk_xor_pair: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    s_xorPair |=> acc == ($past(acc, 2) ^ $past(req.word[7:0], 2) ^ $past(req.word[7:0])))
    else $error("chained xor result wrong");

  chk_xor_decode: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (req.valid && req.word[13:8] == `NSXALU_OP_XORLIT) |-> op == NSXALU_XOR)
    else $error("xor not decoded");

  chk_xor_zero: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_XOR |=> zero == (acc == 8'h00))
    else $error("xor zero flag wrong");

  chk_xor_nonzero: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_XOR && (acc ^ req.word[7:0]) != 8'h00) |=> !zero)
    else $error("xor zero flag set on nonzero result");

  chk_sub_carry: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_SUBLIT |=> carry == ($past(req.word[7:0]) >= $past(acc)))
    else $error("subtract carry wrong");

  chk_subreg_carry: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_SUBREG |=> carry == ($past(req.regData) >= $past(acc)))
    else $error("register subtract carry wrong");

  chk_sub_negative: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SUBREG && req.regData < acc) |=> !carry)
    else $error("negative difference kept carry");

  chk_sublit_wrap: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    op == NSXALU_SUBLIT |=> acc == 8'($past(req.word[7:0]) - $past(acc)))
    else $error("literal subtract result wrong");

  chk_subreg_wrap: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SUBREG && dest) |=> regWr.data == 8'($past(req.regData) - $past(acc)))
    else $error("register subtract result wrong");

  chk_sub_equal: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SUBREG && req.regData == acc && dest) |=> carry && zero && regWr.data == 8'h00)
    else $error("equal subtract wrong");

  chk_sublit_equal: assert property (@(posedge sys_clk) disable iff (!rstSync2)
    (op == NSXALU_SUBLIT && req.word[7:0] == acc) |=> carry && zero && acc == 8'h00)
    else $error("equal literal subtract wrong");
endmodule

// ==== hdl/nsxalu_decode.sv ====
`include "nsxalu_regs.svh"
module nsxalu_decode (
  // instruction word
  input wire logic [13:0] word,
  input wire logic valid,
  // decoded operation
  output nsxalu_pkg::nsxalu_op_t op
);
  import nsxalu_pkg::*;

  always_comb begin
    op = NSXALU_NOP;
    if (valid) begin
      if (word[13:8] == `NSXALU_OP_XORLIT) begin
        op = NSXALU_XOR;
      end else if (word[13:9] == `NSXALU_OP_SUBLIT) begin
        op = NSXALU_SUBLIT;
      end else if (word[13:8] == `NSXALU_OP_SWAP) begin
        op = NSXALU_SWAP;
      end else if (word[13:8] == `NSXALU_OP_SUBREG) begin
        op = NSXALU_SUBREG;
      end
    end
  end
endmodule

// ==== hdl/nsxalu_pkg.sv ====
package nsxalu_pkg;
  typedef enum logic [2:0] {
    NSXALU_NOP,
    NSXALU_SWAP,
    NSXALU_XOR,
    NSXALU_SUBLIT,
    NSXALU_SUBREG
  } nsxalu_op_t;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
    logic [7:0] regData;
  } nsxalu_req_t;

  typedef struct packed {
    logic wrEn;
    logic [6:0] addr;
    logic [7:0] data;
  } nsxalu_wr_t;
endpackage

// ==== hdl/nsxalu_regs.svh ====
`ifndef NSXALU_REGS_SVH
`define NSXALU_REGS_SVH
`define NSXALU_OP_SWAP 6'h0E
`define NSXALU_OP_SUBREG 6'h02
`define NSXALU_OP_XORLIT 6'h3A
`define NSXALU_OP_SUBLIT 5'h1E
`define NSXALU_ACC_RST 8'h00
`define NSXALU_FLAG_RST 1'h0
`define NSXALU_DEST_ACC 1'h0
`define NSXALU_DEST_REG 1'h1
`endif
